// [core/epwms_params.svh]
/*
 Constants for the enhanced PWM steering stage: register offsets, field
 positions, reset values and mode codes. Assumes inclusion by bare name.
*/
`ifndef EPWMS_PARAMS_SVH
`define EPWMS_PARAMS_SVH

// ==========================================
// register map (byte addresses, one word each)
`define EPWMS_ADR_DEL 4'h0
`define EPWMS_ADR_STR 4'h4
`define EPWMS_ADR_CFG 4'h8
`define EPWMS_ADR_SHD 4'hC

// ==========================================
// reset values
`define EPWMS_RST_DEL 8'h00
`define EPWMS_RST_STR 8'h01
`define EPWMS_RST_CFG 8'h00
`define EPWMS_RST_SHD 8'h00

// ==========================================
// field positions
`define EPWMS_DEL_RSEN 7
`define EPWMS_STR_SYNC 4
`define EPWMS_STR_MASK 8'hDF
`define EPWMS_SHD_FLAG 0
`define EPWMS_SHD_SWSET 1

// ==========================================
// mode codes
`define EPWMS_MODE_PWM 2'h3
`define EPWMS_CFG_SINGLE 2'h0
`define EPWMS_COMPLEMENTARY_PAIR_SELECT_NONE 2'h0
`define EPWMS_COMPLEMENTARY_PAIR_SELECT_AB 2'h1
`define EPWMS_COMPLEMENTARY_PAIR_SELECT_AC 2'h2
`define EPWMS_COMPLEMENTARY_PAIR_SELECT_AD 2'h3
`define EPWMS_DB_ZERO 7'h00
`define EPWMS_DB_ONE 7'h01
`define EPWMS_ZERO32 32'h00000000

`endif

// [core/epwms_pkg.sv]
/*
 Types for the enhanced PWM steering stage.
 Assumes epwms_params.svh is compiled alongside.
*/
package epwms_pkg;
   // restart and dead-band control
   typedef struct packed {
      logic auto_restart_enable;
      logic [6:0] dead_band_count;
   } epwms_del_t;

   // steering control
   typedef struct packed {
      logic [1:0] complementary_pair_select;
      logic unused5;
      logic steer_sync_select;
      logic steer_enable_d;
      logic steer_enable_c;
      logic steer_enable_b;
      logic steer_enable_a;
   } epwms_str_t;

   // unit configuration
   typedef struct packed {
      logic [1:0] output_config_bits;
      logic [1:0] mode_hi;
      logic [1:0] polarity;
      logic [1:0] shutdown_level;
   } epwms_cfg_t;

   // shutdown machine states
   typedef enum logic [1:0] {
      EPWMS_RUN,
      EPWMS_SHUT,
      EPWMS_WAIT
   } epwms_state_t;
endpackage

// [core/epwms_top.sv]
/*
 Enhanced PWM output stage: auto-shutdown with restart, dead-band on
 rising edges, pulse steering over four pins, classic Wishbone slave.
 Assumes raw PWM, period start and shutdown condition come from the timer
 and fault logic of the unit, synchronous to MCLK.
*/
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "epwms_params.svh"

module epwms_top (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [3:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   output logic WB_ACK_O,
   input wire logic PWM_RAW,
   input wire logic PERIOD_START,
   input wire logic SHUTDOWN_COND,
   input wire logic SLEEP,
   input wire logic PRIMARY_CLOCK_IDLE,
   input wire logic [3:0] PORT_DATA,
   input wire logic [3:0] PIN_DIRECTION,
   output logic [3:0] PWM_OUT,
   output logic [3:0] PWM_OE
);

   // ==========================================
   // registers
   epwms_pkg::epwms_del_t del_q;
   epwms_pkg::epwms_str_t str_q;
   epwms_pkg::epwms_str_t str_act_q;
   epwms_pkg::epwms_cfg_t cfg_q;
   epwms_pkg::epwms_state_t st_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic [6:0] db_cnt_q;
   logic pwm_db_q;
   logic raw_prev_q;
   logic str_pend_q;
   logic [3:0] out_q;
   logic [3:0] oe_q;

   // ==========================================
   // bus decode
   logic wr_stb;
   logic run;
   logic wr_del;
   logic wr_str;
   logic wr_cfg;
   logic wr_shd;
   logic sw_clr;
   logic sw_set;
   logic steer_mode;
   logic shut;
   logic [3:0] en_mask;
   logic pol_on;

   // a single-cycle answer; ack drops the cycle after it was given
   // writes land on the edge at which the master samples ack high, the one
   // edge at which the whole request is known to be standing
   assign wr_stb = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q && WB_SEL_I[0];
   assign wr_del = wr_stb && (WB_ADR_I == `EPWMS_ADR_DEL);
   assign wr_str = wr_stb && (WB_ADR_I == `EPWMS_ADR_STR);
   assign wr_cfg = wr_stb && (WB_ADR_I == `EPWMS_ADR_CFG);
   assign wr_shd = wr_stb && (WB_ADR_I == `EPWMS_ADR_SHD);
   assign sw_clr = wr_shd && !WB_DAT_I[`EPWMS_SHD_FLAG];
   assign sw_set = wr_shd && WB_DAT_I[`EPWMS_SHD_SWSET];
   // sleep halts steering, shutdown, dead band and pins, while ack, reads and register writes go on; primary idle changes nothing
   assign run = !SLEEP;

   // acknowledge
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
      end
   end
   assign WB_ACK_O = ack_q;

   // read data; unmapped reads return zero
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rdat_q <= `EPWMS_ZERO32;
      end else begin
         case (WB_ADR_I)
            `EPWMS_ADR_DEL: rdat_q <= {24'h000000, del_q};
            `EPWMS_ADR_STR: rdat_q <= {24'h000000, str_q & `EPWMS_STR_MASK};
            `EPWMS_ADR_CFG: rdat_q <= {24'h000000, cfg_q};
            // flag is clear again while the restart waits for the period
            `EPWMS_ADR_SHD: rdat_q <= {30'h00000000, 1'b0, st_q == epwms_pkg::EPWMS_SHUT};
            default: rdat_q <= `EPWMS_ZERO32;
         endcase
      end
   end
   assign WB_DAT_O = rdat_q;

   // control registers
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         del_q <= `EPWMS_RST_DEL;
         str_q <= `EPWMS_RST_STR;
         cfg_q <= `EPWMS_RST_CFG;
      end else begin
         if (wr_del) begin
            del_q <= WB_DAT_I[7:0];
         end
         if (wr_str) begin
            str_q <= WB_DAT_I[7:0] & `EPWMS_STR_MASK;
         end
         if (wr_cfg) begin
            cfg_q <= WB_DAT_I[7:0];
         end
      end
   end

   // ==========================================
   // steering update, immediate or at period start
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         str_act_q <= `EPWMS_RST_STR;
         str_pend_q <= 1'b0;
      end else if (run) begin
         if (wr_str && !WB_DAT_I[`EPWMS_STR_SYNC]) begin
            str_act_q <= WB_DAT_I[7:0] & `EPWMS_STR_MASK;
            str_pend_q <= 1'b0;
         end else if (wr_str) begin
            str_pend_q <= 1'b1;
         end else if (str_pend_q && PERIOD_START) begin
            str_act_q <= str_q;
            str_pend_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // shutdown flag and restart machine
   // set wins over a software clear in the same cycle
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         st_q <= epwms_pkg::EPWMS_RUN;
      end else if (run) begin
         case (st_q)
            epwms_pkg::EPWMS_RUN: begin
               if (SHUTDOWN_COND || sw_set) begin
                  st_q <= epwms_pkg::EPWMS_SHUT;
               end
            end
            epwms_pkg::EPWMS_SHUT: begin
               if (SHUTDOWN_COND || sw_set) begin
                  st_q <= epwms_pkg::EPWMS_SHUT;
               end else if (del_q.auto_restart_enable) begin
                  st_q <= epwms_pkg::EPWMS_WAIT;
               end else if (sw_clr) begin
                  st_q <= epwms_pkg::EPWMS_WAIT;
               end
            end
            epwms_pkg::EPWMS_WAIT: begin
               // flag already clear; outputs held off until period start
               if (SHUTDOWN_COND || sw_set) begin
                  st_q <= epwms_pkg::EPWMS_SHUT;
               end else if (PERIOD_START) begin
                  st_q <= epwms_pkg::EPWMS_RUN;
               end
            end
            default: st_q <= epwms_pkg::EPWMS_RUN;
         endcase
      end
   end
   assign shut = (st_q != epwms_pkg::EPWMS_RUN);

   // ==========================================
   // dead band: only the rising edge is delayed
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         db_cnt_q <= `EPWMS_DB_ZERO;
         pwm_db_q <= 1'b0;
         raw_prev_q <= 1'b0;
      end else if (run) begin
         raw_prev_q <= PWM_RAW;
         if (!PWM_RAW) begin
            pwm_db_q <= 1'b0;
            db_cnt_q <= `EPWMS_DB_ZERO;
         end else if (!raw_prev_q) begin
            if (del_q.dead_band_count == `EPWMS_DB_ZERO) begin
               pwm_db_q <= 1'b1;
            end else begin
               db_cnt_q <= del_q.dead_band_count;
            end
         end else if (db_cnt_q == `EPWMS_DB_ONE) begin
            pwm_db_q <= 1'b1;
            db_cnt_q <= `EPWMS_DB_ZERO;
         end else if (db_cnt_q != `EPWMS_DB_ZERO) begin
            db_cnt_q <= db_cnt_q - `EPWMS_DB_ONE;
         end
      end
   end

   // ==========================================
   // steering mask and pin drive
   assign steer_mode = (cfg_q.mode_hi == `EPWMS_MODE_PWM) &&
                       (cfg_q.output_config_bits == `EPWMS_CFG_SINGLE);
   always_comb begin
      case (str_act_q.complementary_pair_select)
         `EPWMS_COMPLEMENTARY_PAIR_SELECT_AB: en_mask = 4'h3;
         `EPWMS_COMPLEMENTARY_PAIR_SELECT_AC: en_mask = 4'h5;
         `EPWMS_COMPLEMENTARY_PAIR_SELECT_AD: en_mask = 4'h9;
         default: en_mask = {str_act_q.steer_enable_d, str_act_q.steer_enable_c,
                             str_act_q.steer_enable_b, str_act_q.steer_enable_a};
      endcase
   end
   // polarity bit 0 set means active low
   assign pol_on = pwm_db_q ^ cfg_q.polarity[0];

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         out_q <= 4'h0;
         oe_q <= 4'h0;
      end else if (run) begin
         for (int i = 0; i < 4; i++) begin
            if (steer_mode && en_mask[i]) begin
               // shutdown touches only pins carrying PWM
               if (shut) begin
                  out_q[i] <= cfg_q.shutdown_level[0];
                  oe_q[i] <= !cfg_q.shutdown_level[1] && !PIN_DIRECTION[i];
               end else begin
                  out_q[i] <= pol_on;
                  oe_q[i] <= !PIN_DIRECTION[i];
               end
            end else begin
               out_q[i] <= PORT_DATA[i];
               oe_q[i] <= !PIN_DIRECTION[i];
            end
         end
      end
   end
   assign PWM_OUT = out_q;
   assign PWM_OE = oe_q;

   // ==========================================
   // checks
   AST_ACK_ONE: assert property (@(posedge MCLK) disable iff (SRST)
      WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
   AST_BIT5_ZERO: assert property (@(posedge MCLK) disable iff (SRST)
      !str_q.unused5) else $error("bit five stored");
   AST_RESTART: assert property (@(posedge MCLK) disable iff (SRST)
      (st_q == epwms_pkg::EPWMS_SHUT && !SHUTDOWN_COND && !sw_set && run &&
       del_q.auto_restart_enable) |=> st_q == epwms_pkg::EPWMS_WAIT)
      else $error("auto restart missed");
   AST_HOLD: assert property (@(posedge MCLK) disable iff (SRST)
      (st_q == epwms_pkg::EPWMS_SHUT && !del_q.auto_restart_enable && !sw_clr)
      |=> st_q == epwms_pkg::EPWMS_SHUT) else $error("left shutdown alone");
   AST_WAIT_PERIOD: assert property (@(posedge MCLK) disable iff (SRST)
      (st_q == epwms_pkg::EPWMS_WAIT && !PERIOD_START) |=> st_q != epwms_pkg::EPWMS_RUN)
      else $error("restart before period");
   AST_FALL_NODELAY: assert property (@(posedge MCLK) disable iff (SRST)
      (!PWM_RAW && run) |=> !pwm_db_q) else $error("falling edge delayed");
   AST_ZERO_DB: assert property (@(posedge MCLK) disable iff (SRST)
      (PWM_RAW && !raw_prev_q && run && del_q.dead_band_count == `EPWMS_DB_ZERO)
      |=> pwm_db_q) else $error("zero count delayed");
   AST_DB_HOLD: assert property (@(posedge MCLK) disable iff (SRST)
      (db_cnt_q > `EPWMS_DB_ONE && PWM_RAW && raw_prev_q) |=> !pwm_db_q)
      else $error("edge too early");
   AST_IMMED: assert property (@(posedge MCLK) disable iff (SRST)
      (wr_str && run && !WB_DAT_I[`EPWMS_STR_SYNC]) |=>
      (str_act_q == ($past(WB_DAT_I[7:0]) & `EPWMS_STR_MASK)))
      else $error("steering not immediate");
   AST_SLEEP: assert property (@(posedge MCLK) disable iff (SRST)
      SLEEP |=> $stable(out_q) && $stable(oe_q)) else $error("pins moved in sleep");
   AST_PORT: assert property (@(posedge MCLK) disable iff (SRST)
      (!steer_mode && run) |=> out_q == $past(PORT_DATA)) else $error("port not passed");

   // ==========================================
   // pin, register and steering checks
   // pins show what was chosen one edge earlier, so the pin checks take mask, waveform, port and level with $past
   AST_STEERED: assert property (@(posedge MCLK) disable iff (SRST)
      (run && steer_mode && !shut) |=>
      ((PWM_OUT & $past(en_mask)) == ({4{$past(pol_on)}} & $past(en_mask))))
      else $error("steered pin lost the waveform");
   AST_UNSTEERED: assert property (@(posedge MCLK) disable iff (SRST)
      (run && steer_mode) |=>
      ((PWM_OUT & ~$past(en_mask)) == ($past(PORT_DATA) & ~$past(en_mask))))
      else $error("unsteered pin not port");
   AST_SHUT_LEVEL: assert property (@(posedge MCLK) disable iff (SRST)
      (run && steer_mode && shut) |=>
      ((PWM_OUT & $past(en_mask)) == ({4{$past(cfg_q.shutdown_level[0])}} & $past(en_mask))))
      else $error("shutdown level wrong");
   AST_SHUT_TRI: assert property (@(posedge MCLK) disable iff (SRST)
      (run && steer_mode && shut && cfg_q.shutdown_level[1]) |=>
      ((PWM_OE & $past(en_mask)) == 4'h0))
      else $error("shutdown pin still driven");
   AST_PEND: assert property (@(posedge MCLK) disable iff (SRST)
      (str_pend_q && PERIOD_START && run && !wr_str) |=> (str_act_q == $past(str_q)))
      else $error("deferred steering not applied");
   AST_DEFER: assert property (@(posedge MCLK) disable iff (SRST)
      (wr_str && WB_DAT_I[`EPWMS_STR_SYNC]) |=> $stable(str_act_q))
      else $error("synced steering applied early");
   AST_IDLE: assert property (@(posedge MCLK) disable iff (SRST)
      (PRIMARY_CLOCK_IDLE && !SLEEP) |-> run) else $error("idle stopped the module");
   AST_RST_PINS: assert property (@(posedge MCLK)
      SRST |=> (PWM_OE == 4'h0)) else $error("pins driven after reset");
   AST_RST_REGS: assert property (@(posedge MCLK)
      SRST |=> (del_q == `EPWMS_RST_DEL && str_q == `EPWMS_RST_STR &&
                cfg_q == `EPWMS_RST_CFG && st_q == epwms_pkg::EPWMS_RUN))
      else $error("registers not reset");
   AST_WR_LAND: assert property (@(posedge MCLK) disable iff (SRST)
      wr_del |=> (del_q == $past(WB_DAT_I[7:0]))) else $error("write did not land");
   COV_SHUT: cover property (@(posedge MCLK) st_q == epwms_pkg::EPWMS_SHUT);
   COV_REST: cover property (@(posedge MCLK)
      st_q == epwms_pkg::EPWMS_WAIT ##1 st_q == epwms_pkg::EPWMS_RUN);
   COV_DB: cover property (@(posedge MCLK) db_cnt_q == `EPWMS_DB_ONE);
   COV_SYNC: cover property (@(posedge MCLK) str_pend_q && PERIOD_START);
   COV_SWSET: cover property (@(posedge MCLK) sw_set);
endmodule

`default_nettype wire

// [test/epwms_switch_model.sv]
/*
 Model of the external switch drivers on the four PWM pins.
 Assumes pull-downs keep each switch off while its pin floats.
*/
`timescale 1ns/1ps
`default_nettype none

module epwms_switch_model (
   input wire logic [3:0] PWM_OUT,
   input wire logic [3:0] PWM_OE,
   output logic [3:0] PIN_LEVEL
);
   // ==========================================
   // pin resolution
   // a released pin falls to its pull-down, never to the last value
   assign PIN_LEVEL = PWM_OUT & PWM_OE;
endmodule
`default_nettype wire

// [test/epwms_tb.sv]
/*
 Self-checking bench for the PWM steering stage: Wishbone register
 tasks, pin checks against expected levels. Assumes one 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "epwms_params.svh"

module epwms_tb;
   logic MCLK, SRST, WB_WE_I, WB_CYC_I, WB_STB_I, WB_ACK_O, PWM_RAW, PERIOD_START;
   logic SHUTDOWN_COND, SLEEP, PRIMARY_CLOCK_IDLE;
   logic [3:0] WB_ADR_I, WB_SEL_I, PORT_DATA, PIN_DIRECTION, PWM_OUT, PWM_OE, PIN_LEVEL;
   logic [31:0] WB_DAT_I, WB_DAT_O, rd_q;
   int bad_count, compares, cycles;

   // ==========================================
   // design and far side
   epwms_top epwms_top_inst (.MCLK(MCLK), .SRST(SRST), .WB_ADR_I(WB_ADR_I),
      .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I),
      .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .PWM_RAW(PWM_RAW),
      .PERIOD_START(PERIOD_START), .SHUTDOWN_COND(SHUTDOWN_COND), .SLEEP(SLEEP),
      .PRIMARY_CLOCK_IDLE(PRIMARY_CLOCK_IDLE), .PORT_DATA(PORT_DATA),
      .PIN_DIRECTION(PIN_DIRECTION), .PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE));
   epwms_switch_model epwms_switch_model_inst (.PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE),
      .PIN_LEVEL(PIN_LEVEL));

   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one classic cycle raised just after an edge; ack and data are taken on
   // the rising edge that samples ack high, then one idle cycle follows
   task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat);
      int k;
      k = 0;
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= adr;
      WB_DAT_I <= {24'h000000, dat};
      do begin
         @(posedge MCLK);
         k++;
      end while (WB_ACK_O !== 1'b1 && k < 20);
      rd_q = WB_DAT_O;
      if (k >= 20) begin
         bad_count++;
         $display("[FAIL] t=%0t ack wait got=%h exp=%h", $time, WB_ACK_O, 1'b1);
      end
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic rd(input logic [3:0] adr, input logic [7:0] exp);
      wb(1'b0, adr, 8'h00);
      chk(rd_q, {24'h000000, exp});
   endtask

   task automatic pins(input int w, input logic [3:0] exp);
      repeat (w) @(posedge MCLK);
      @(negedge MCLK);
      chk({28'h0000000, PWM_OUT}, {28'h0000000, exp});
      @(posedge MCLK);
   endtask

   // counts clock cycles until pin A follows the raw level
   task automatic edge_delay(input logic lvl, input int exp);
      int k;
      k = 0;
      PWM_RAW <= lvl;
      do begin
         @(negedge MCLK);
         k++;
      end while (PWM_OUT[0] !== lvl && k < 300);
      chk(k, exp);
      @(posedge MCLK);
   endtask

   task automatic pulse();
      PERIOD_START <= 1'b1;
      @(posedge MCLK);
      PERIOD_START <= 1'b0;
   endtask

   task automatic conclude();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================
   // clock and hang guard, ceiling well above the sequence length
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         $display("[FAIL] t=%0t timeout got=%h exp=%h", $time, cycles, 20000);
         conclude();
      end
   end

   // ==========================================
   // main sequence
   initial begin
      {SRST, WB_WE_I, WB_CYC_I, WB_STB_I, PWM_RAW, PERIOD_START} <= 6'h20;
      {SHUTDOWN_COND, SLEEP, PRIMARY_CLOCK_IDLE} <= 3'h0;
      {WB_ADR_I, PORT_DATA, PIN_DIRECTION, WB_DAT_I} <= 44'h0;
      WB_SEL_I <= 4'hF;
      repeat (12) @(posedge MCLK);
      SRST <= 1'b0;
      chk(PWM_OE | PIN_LEVEL, 32'h0);
      rd(`EPWMS_ADR_DEL, 8'h00);
      rd(`EPWMS_ADR_STR, 8'h01);
      rd(`EPWMS_ADR_CFG, 8'h00);
      rd(`EPWMS_ADR_SHD, 8'h00);
      rd(4'h2, 8'h00);
      wb(1'b1, `EPWMS_ADR_STR, 8'hFF);
      rd(`EPWMS_ADR_STR, 8'hDF);
      $display("test registers done");
      // steering routes and polarity, idle has no effect
      PORT_DATA <= 4'h2;
      PWM_RAW <= 1'b1;
      PRIMARY_CLOCK_IDLE <= 1'b1;
      wb(1'b1, `EPWMS_ADR_CFG, 8'h30);
      wb(1'b1, `EPWMS_ADR_STR, 8'h0F);
      pins(3, 4'hF);
      chk(PWM_OE, 32'hF);
      wb(1'b1, `EPWMS_ADR_STR, 8'h05);
      pins(3, 4'h7);
      wb(1'b1, `EPWMS_ADR_CFG, 8'h34);
      pins(3, 4'h2);
      wb(1'b1, `EPWMS_ADR_CFG, 8'h04);
      pins(3, 4'h2);
      wb(1'b1, `EPWMS_ADR_CFG, 8'hB0);
      pins(3, 4'h2);
      // active-low steered pins read 0 against a port of all ones
      wb(1'b1, `EPWMS_ADR_CFG, 8'h34);
      PORT_DATA <= 4'hF;
      for (int i = 1; i < 4; i++) begin
         wb(1'b1, `EPWMS_ADR_STR, {i[1:0], 6'h00});
         pins(3, ~(4'h1 | (4'h1 << i)));
      end
      wb(1'b1, `EPWMS_ADR_CFG, 8'h30);
      $display("test steering done");
      // update timing of steering writes
      PORT_DATA <= 4'h0;
      wb(1'b1, `EPWMS_ADR_STR, 8'h01);
      pins(3, 4'h1);
      wb(1'b1, `EPWMS_ADR_STR, 8'h12);
      pins(4, 4'h1);
      pulse();
      pins(2, 4'h2);
      wb(1'b1, `EPWMS_ADR_STR, 8'h04);
      pins(3, 4'h4);
      $display("test sync done");
      // dead band on rising edges only
      wb(1'b1, `EPWMS_ADR_STR, 8'h01);
      PWM_RAW <= 1'b0;
      pins(3, 4'h0);
      edge_delay(1'b1, 3);
      edge_delay(1'b0, 3);
      wb(1'b1, `EPWMS_ADR_DEL, 8'h05);
      edge_delay(1'b1, 8);
      edge_delay(1'b0, 3);
      wb(1'b1, `EPWMS_ADR_DEL, 8'h7F);
      edge_delay(1'b1, 130);
      edge_delay(1'b0, 3);
      $display("test dead band done");
      // shutdown with software restart, then automatic restart
      wb(1'b1, `EPWMS_ADR_DEL, 8'h00);
      wb(1'b1, `EPWMS_ADR_STR, 8'h03);
      wb(1'b1, `EPWMS_ADR_CFG, 8'h31);
      SHUTDOWN_COND <= 1'b1;
      pins(3, 4'h3);
      rd(`EPWMS_ADR_SHD, 8'h01);
      SHUTDOWN_COND <= 1'b0;
      pins(4, 4'h3);
      rd(`EPWMS_ADR_SHD, 8'h01);
      wb(1'b1, `EPWMS_ADR_SHD, 8'h00);
      rd(`EPWMS_ADR_SHD, 8'h00);
      pins(4, 4'h3);
      pulse();
      pins(3, 4'h0);
      // software shutdown with released pins, then a software restart
      wb(1'b1, `EPWMS_ADR_CFG, 8'h33);
      wb(1'b1, `EPWMS_ADR_SHD, 8'h03);
      pins(3, 4'h3);
      chk(PWM_OE, 32'hC);
      chk(PIN_LEVEL, 32'h0);
      rd(`EPWMS_ADR_SHD, 8'h01);
      wb(1'b1, `EPWMS_ADR_SHD, 8'h00);
      pulse();
      pins(3, 4'h0);
      wb(1'b1, `EPWMS_ADR_DEL, 8'h80);
      SHUTDOWN_COND <= 1'b1;
      pins(3, 4'h3);
      SHUTDOWN_COND <= 1'b0;
      pins(4, 4'h3);
      rd(`EPWMS_ADR_SHD, 8'h00);
      pulse();
      pins(3, 4'h0);
      $display("test shutdown done");
      // sleep freezes pins, then a second reset mid-run
      wb(1'b1, `EPWMS_ADR_STR, 8'h01);
      PWM_RAW <= 1'b1;
      pins(3, 4'h1);
      SLEEP <= 1'b1;
      PWM_RAW <= 1'b0;
      pins(5, 4'h1);
      SLEEP <= 1'b0;
      pins(4, 4'h0);
      PWM_RAW <= 1'b1;
      pins(3, 4'h1);
      SRST <= 1'b1;
      pins(3, 4'h0);
      chk(PWM_OE, 32'h0);
      SRST <= 1'b0;
      rd(`EPWMS_ADR_STR, 8'h01);
      rd(`EPWMS_ADR_CFG, 8'h00);
      $display("test sleep and reset done");
      conclude();
   end
endmodule
`default_nettype wire
